// ===== rtl/prm_mask_bank.sv
// Purpose: per-source masking of rail power-good and current-limit events onto sticky flags
// Assumes: AHB-Lite single slave, word transfers, byte address is four times register index
// Notes: mask defaults come from the otp port once after reset release
//
// Behaviour
// - second step-down invalid edge sets its pg flag only if step-down mask bit 7 clear
// - second step-down valid edge sets its pg flag only if step-down mask bit 6 clear
// - second step-down current limit sets its flag only if step-down mask bit 4 clear
// - first step-down invalid edge sets its pg flag only if step-down mask bit 3 clear
// - first step-down valid edge sets its pg flag only if step-down mask bit 2 clear
// - first step-down current limit sets its flag only if step-down mask bit 0 clear
// - boost invalid edge sets boost pg flag only if boost mask bit 3 clear
// - boost valid edge sets boost pg flag only if boost mask bit 2 clear
// - boost current limit sets its flag only if boost mask bit 0 clear
// - monitor two invalid edge sets its flag only if diag_monitor_event_masks bit 5 clear
// - mask 0 lets the event through, mask 1 suppresses it
// - masks gate flags only; raw status always follows the live condition
// - mask defaults load from otp on the first edge after reset release; software may overwrite later
// - monitor two valid edge sets its flag only if diag_monitor_event_masks bit 4 clear
// - monitor one: diag bit 3 gates invalid, bit 2 gates valid edge
// - analog supply: diag bit 1 gates invalid, bit 0 gates valid edge
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "prm_params.svh"

module prm_mask_bank #(
    parameter int N_SRC = `PRM_N_SRC
) (
    input wire logic hclk, // system clock, 250 MHz
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size, word expected
    input wire logic hready, // bus ready
    input wire logic [31:0] hwdata, // write data
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    input wire logic [N_SRC-1:0] sense_in, // raw pg and current-limit pins, flag layout
    input wire logic [23:0] otp_mask_default, // {diag, boost, step-down} mask defaults
    output logic irq // level interrupt
);

    prm_evt_if #(.N(N_SRC)) evt ();

    prm_sense_filter #(.N(N_SRC)) u_filter (
        .hclk(hclk),
        .hresetn(hresetn),
        .sense_in(sense_in),
        .evt(evt.src)
    );

    prm_pkg::prm_bus_state_type state_q;
    prm_pkg::prm_mask_type step_down_event_masks_q;
    prm_pkg::prm_mask_type boost_event_masks_q;
    prm_pkg::prm_mask_type diag_monitor_event_masks_q;
    logic [N_SRC-1:0] flags_q;
    logic [N_SRC-1:0] flags_d;
    logic [N_SRC-1:0] flag_mask_q;
    logic [N_SRC-1:0] set_vec;
    logic [N_SRC-1:0] clr_vec;
    logic [7:0] addr_q;
    logic addr_ok_q;
    logic loaded_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;
    logic irq_q;
    logic acc;
    logic wr;

    function automatic logic hit(input logic [7:0] a, input logic ok, input logic [7:0] idx);
        hit = ok && (a == idx);
    endfunction

    function automatic logic [N_SRC-1:0] event_set(
        input logic [N_SRC-1:0] r,
        input logic [N_SRC-1:0] f,
        input logic [7:0] sd,
        input logic [7:0] up,
        input logic [7:0] dg
    );
        logic [N_SRC-1:0] s;
        s = '0;
        s[`PRM_F_SD0_CURLIM] = r[`PRM_F_SD0_CURLIM] && !sd[`PRM_SD0_CURLIM];
        s[`PRM_F_SD0_PG] = (r[`PRM_F_SD0_PG] && !sd[`PRM_SD0_RISE])
            || (f[`PRM_F_SD0_PG] && !sd[`PRM_SD0_FALL]);
        s[`PRM_F_SD1_CURLIM] = r[`PRM_F_SD1_CURLIM] && !sd[`PRM_SD1_CURLIM];
        s[`PRM_F_SD1_PG] = (r[`PRM_F_SD1_PG] && !sd[`PRM_SD1_RISE])
            || (f[`PRM_F_SD1_PG] && !sd[`PRM_SD1_FALL]);
        s[`PRM_F_UP_CURLIM] = r[`PRM_F_UP_CURLIM] && !up[`PRM_UP_CURLIM];
        s[`PRM_F_UP_PG] = (r[`PRM_F_UP_PG] && !up[`PRM_UP_RISE])
            || (f[`PRM_F_UP_PG] && !up[`PRM_UP_FALL]);
        s[`PRM_F_ANA_PG] = (r[`PRM_F_ANA_PG] && !dg[`PRM_ANA_RISE])
            || (f[`PRM_F_ANA_PG] && !dg[`PRM_ANA_FALL]);
        s[`PRM_F_MON1_PG] = (r[`PRM_F_MON1_PG] && !dg[`PRM_MON1_RISE])
            || (f[`PRM_F_MON1_PG] && !dg[`PRM_MON1_FALL]);
        s[`PRM_F_MON2_PG] = (r[`PRM_F_MON2_PG] && !dg[`PRM_MON2_RISE])
            || (f[`PRM_F_MON2_PG] && !dg[`PRM_MON2_FALL]);
        event_set = s;
    endfunction

    assign acc = hsel && htrans[1] && hready;
    assign wr = (state_q == prm_pkg::BUS_WRITE);

    // bus phase tracking; reads insert one wait state so the data reflects a preceding write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= prm_pkg::BUS_IDLE;
        end else begin
            case (state_q)
                prm_pkg::BUS_IDLE, prm_pkg::BUS_WRITE: begin
                    if (acc) begin
                        state_q <= hwrite ? prm_pkg::BUS_WRITE : prm_pkg::BUS_READ;
                    end else begin
                        state_q <= prm_pkg::BUS_IDLE;
                    end
                end
                prm_pkg::BUS_READ: begin
                    state_q <= prm_pkg::BUS_IDLE;
                end
                default: begin
                    state_q <= prm_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q <= 8'h00;
            addr_ok_q <= 1'b0;
        end else if (acc) begin
            addr_q <= haddr[9:2];
            addr_ok_q <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
        end else if (acc && !hwrite) begin
            hreadyout_q <= 1'b0;
        end else if (state_q == prm_pkg::BUS_READ) begin
            hreadyout_q <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_q <= 1'b0;
        end else begin
            hresp_q <= 1'b0;
        end
    end

    // unmapped addresses read as zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h00000000;
        end else if (state_q == prm_pkg::BUS_READ) begin
            hrdata_q <= 32'h00000000;
            if (hit(addr_q, addr_ok_q, `PRM_IDX_STEP_DOWN)) begin
                hrdata_q[7:0] <= step_down_event_masks_q;
            end
            if (hit(addr_q, addr_ok_q, `PRM_IDX_BOOST)) begin
                hrdata_q[7:0] <= boost_event_masks_q;
            end
            if (hit(addr_q, addr_ok_q, `PRM_IDX_DIAG)) begin
                hrdata_q[7:0] <= diag_monitor_event_masks_q;
            end
            if (hit(addr_q, addr_ok_q, `PRM_IDX_FLAGS)) begin
                hrdata_q[N_SRC-1:0] <= flags_q;
            end
            if (hit(addr_q, addr_ok_q, `PRM_IDX_FLAG_MASK)) begin
                hrdata_q[N_SRC-1:0] <= flag_mask_q;
            end
            if (hit(addr_q, addr_ok_q, `PRM_IDX_RAW)) begin
                hrdata_q[N_SRC-1:0] <= evt.level;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loaded_q <= 1'b0;
        end else begin
            loaded_q <= 1'b1;
        end
    end

    // otp defaults land on the first edge after release with reserved bits zero; software writes store all eight bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_down_event_masks_q <= `PRM_RST_MASK;
            boost_event_masks_q <= `PRM_RST_MASK;
            diag_monitor_event_masks_q <= `PRM_RST_MASK;
        end else if (!loaded_q) begin
            step_down_event_masks_q <= otp_mask_default[7:0] & `PRM_DEF_STEP_DOWN;
            boost_event_masks_q <= otp_mask_default[15:8] & `PRM_DEF_BOOST;
            diag_monitor_event_masks_q <= otp_mask_default[23:16] & `PRM_DEF_DIAG;
        end else if (wr) begin
            if (hit(addr_q, addr_ok_q, `PRM_IDX_STEP_DOWN)) begin
                step_down_event_masks_q <= hwdata[7:0];
            end
            if (hit(addr_q, addr_ok_q, `PRM_IDX_BOOST)) begin
                boost_event_masks_q <= hwdata[7:0];
            end
            if (hit(addr_q, addr_ok_q, `PRM_IDX_DIAG)) begin
                diag_monitor_event_masks_q <= hwdata[7:0];
            end
        end
    end

    always_comb begin
        set_vec = event_set(evt.rise, evt.fall, step_down_event_masks_q, boost_event_masks_q,
            diag_monitor_event_masks_q);
        clr_vec = (wr && hit(addr_q, addr_ok_q, `PRM_IDX_FLAGS)) ? hwdata[N_SRC-1:0] : '0;
        flags_d = (flags_q & ~clr_vec) | set_vec;
    end

    // write one to clear; a new event in the clearing cycle keeps the flag set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_q <= `PRM_RST_FLAGS;
        end else begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_mask_q <= `PRM_RST_FLAG_MASK;
        end else if (wr && hit(addr_q, addr_ok_q, `PRM_IDX_FLAG_MASK)) begin
            flag_mask_q <= hwdata[N_SRC-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flags_q & ~flag_mask_q);
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign irq = irq_q;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_rd_addr;
        hsel && htrans[1] && hready && !hwrite;
    endsequence

    sequence s_rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence

    chk_read_wait_state: assert property (s_rd_addr |=> s_rd_answer)
        else $error("read answer not after one wait state");

    chk_sd1_fall_pass: assert property (
        (evt.fall[`PRM_F_SD1_PG] && !step_down_event_masks_q[`PRM_SD1_FALL]) |=> flags_q[`PRM_F_SD1_PG])
        else $error("unmasked sd1 invalid edge did not set flag");

    chk_sd1_rise_block: assert property (
        (evt.rise[`PRM_F_SD1_PG] && step_down_event_masks_q[`PRM_SD1_RISE] && !flags_q[`PRM_F_SD1_PG])
        |=> !flags_q[`PRM_F_SD1_PG])
        else $error("masked sd1 valid edge set flag");

    chk_sd1_curlim_gate: assert property (
        (evt.rise[`PRM_F_SD1_CURLIM] && !step_down_event_masks_q[`PRM_SD1_CURLIM])
        |=> flags_q[`PRM_F_SD1_CURLIM])
        else $error("sd1 current limit flag missed");

    chk_sd0_fall_block: assert property (
        (evt.fall[`PRM_F_SD0_PG] && step_down_event_masks_q[`PRM_SD0_FALL] && !flags_q[`PRM_F_SD0_PG])
        |=> !flags_q[`PRM_F_SD0_PG])
        else $error("masked sd0 invalid edge set flag");

    chk_boost_curlim_block: assert property (
        (evt.rise[`PRM_F_UP_CURLIM] && boost_event_masks_q[`PRM_UP_CURLIM] && !flags_q[`PRM_F_UP_CURLIM])
        |=> !flags_q[`PRM_F_UP_CURLIM])
        else $error("masked boost current limit set flag");

    chk_mon2_fall_pass: assert property (
        (evt.fall[`PRM_F_MON2_PG] && !diag_monitor_event_masks_q[`PRM_MON2_FALL]) |=> flags_q[`PRM_F_MON2_PG])
        else $error("unmasked monitor two invalid edge missed");

    chk_otp_default_load: assert property (
        $rose(loaded_q) |-> (boost_event_masks_q == ($past(otp_mask_default[15:8]) & `PRM_DEF_BOOST)))
        else $error("boost masks not loaded from otp");

    chk_irq_follows_flags: assert property (
        (|(flags_q & ~flag_mask_q)) |=> irq)
        else $error("interrupt output not raised for an unmasked flag");

    chk_irq_quiet_flags: assert property (
        (!(|(flags_q & ~flag_mask_q))) |=> !irq)
        else $error("interrupt output raised with no unmasked flag");

endmodule

`default_nettype wire

// ===== rtl/prm_params.svh
// Purpose: register indices, field positions, reset values and counts of the rail mask bank
// Assumes: included by its bare name by every file that needs these numbers
// Notes: byte address of a register is four times its index
`ifndef PRM_PARAMS_SVH
`define PRM_PARAMS_SVH

`define PRM_IDX_STEP_DOWN 8'h2B
`define PRM_IDX_BOOST 8'h2C
`define PRM_IDX_DIAG 8'h2D
`define PRM_IDX_FLAGS 8'h40
`define PRM_IDX_FLAG_MASK 8'h41
`define PRM_IDX_RAW 8'h42

`define PRM_RST_MASK 8'h00
`define PRM_RST_FLAGS 9'h000
`define PRM_RST_FLAG_MASK 9'h000

`define PRM_DEF_STEP_DOWN 8'hDD
`define PRM_DEF_BOOST 8'h0D
`define PRM_DEF_DIAG 8'h3F

`define PRM_SD1_FALL 7
`define PRM_SD1_RISE 6
`define PRM_SD1_CURLIM 4
`define PRM_SD0_FALL 3
`define PRM_SD0_RISE 2
`define PRM_SD0_CURLIM 0
`define PRM_UP_FALL 3
`define PRM_UP_RISE 2
`define PRM_UP_CURLIM 0
`define PRM_MON2_FALL 5
`define PRM_MON2_RISE 4
`define PRM_MON1_FALL 3
`define PRM_MON1_RISE 2
`define PRM_ANA_FALL 1
`define PRM_ANA_RISE 0

`define PRM_F_SD0_CURLIM 0
`define PRM_F_SD0_PG 1
`define PRM_F_SD1_CURLIM 2
`define PRM_F_SD1_PG 3
`define PRM_F_UP_CURLIM 4
`define PRM_F_UP_PG 5
`define PRM_F_ANA_PG 6
`define PRM_F_MON1_PG 7
`define PRM_F_MON2_PG 8

`define PRM_N_SRC 9

`endif

// ===== rtl/prm_pkg.sv
// Purpose: shared types of the rail mask bank
// Assumes: nothing
// Notes: used by scoped name only
package prm_pkg;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ = 2'b10
    } prm_bus_state_type;

    typedef logic [7:0] prm_mask_type;

endpackage

// ===== rtl/prm_evt_if.sv
// Purpose: carries filtered sense levels and their edge pulses between the filter and the bank
// Assumes: one clock domain
// Notes: bit layout is the interrupt flag layout
`timescale 1ns/10ps
`default_nettype none

interface prm_evt_if #(parameter int N = 9);
    logic [N-1:0] level;
    logic [N-1:0] rise;
    logic [N-1:0] fall;

    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface

`default_nettype wire

// ===== rtl/prm_sense_filter.sv
// Purpose: brings raw sense pins into the clock domain and marks their valid and invalid edges
// Assumes: sense pins are asynchronous levels
// Notes: a change is taken once the second and third stages agree
`timescale 1ns/10ps
`default_nettype none

module prm_sense_filter #(
    parameter int N = 9
) (
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, active low
    input wire logic [N-1:0] sense_in, // raw sense pins
    prm_evt_if.src evt // filtered levels and edge pulses
);

    logic [N-1:0] sync1_q;
    logic [N-1:0] sync2_q;
    logic [N-1:0] sync3_q;
    logic [N-1:0] level_q;
    logic [N-1:0] rise_q;
    logic [N-1:0] fall_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= sense_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // agreed value only; a one-cycle glitch between stages is ignored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_q <= '0;
            rise_q <= '0;
            fall_q <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (sync2_q[i] == sync3_q[i]) begin
                    level_q[i] <= sync3_q[i];
                end
                rise_q[i] <= (sync2_q[i] == sync3_q[i]) && sync3_q[i] && !level_q[i];
                fall_q[i] <= (sync2_q[i] == sync3_q[i]) && !sync3_q[i] && level_q[i];
            end
        end
    end

    assign evt.level = level_q;
    assign evt.rise = rise_q;
    assign evt.fall = fall_q;

endmodule

`default_nettype wire

// ===== verif/prm_mask_bank_tb_top.sv
// Purpose: self-checking bench of the rail mask bank, driven over AHB-Lite and the sense pins
// Assumes: one 250 MHz clock, single word transfers, hready fed back from hreadyout
// Notes: events are table driven; mask values and otp defaults are random from a fixed seed
`timescale 1ns/10ps
`default_nettype none
`include "prm_params.svh"
`define TB_CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); end end

module prm_mask_bank_tb_top;
    logic hclk = 1'b0;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [8:0] sense_in;
    logic [23:0] otp_mask_default;
    logic irq;
    logic [31:0] rd;
    int fail_count = 0;
    int checks_done = 0;
    // per event: source bit, rising edge or not, mask register group, mask bit
    int ev_src[15] = '{3, 3, 2, 1, 1, 0, 5, 5, 4, 8, 8, 7, 7, 6, 6};
    bit ev_rise[15] = '{0, 1, 1, 0, 1, 1, 0, 1, 1, 0, 1, 0, 1, 0, 1};
    int ev_grp[15] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 2, 2};
    int ev_bit[15] = '{7, 6, 4, 3, 2, 0, 3, 2, 0, 5, 4, 3, 2, 1, 0};
    logic [7:0] idx_of[3] = '{`PRM_IDX_STEP_DOWN, `PRM_IDX_BOOST, `PRM_IDX_DIAG};

    always #2 hclk = ~hclk;

    prm_mask_bank i_dut (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hreadyout),
        .hwdata(hwdata),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .sense_in(sense_in),
        .otp_mask_default(otp_mask_default),
        .irq(irq)
    );

    function automatic logic [31:0] exp_flags(input int src, input logic m);
        return m ? 32'h0 : (32'h1 << src);
    endfunction

    function automatic logic [31:0] exp_default(input logic [7:0] otp, input logic [7:0] defined);
        return {24'h0, otp & defined};
    endfunction

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // bounded wait for hready sampled high at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin
            fail_count++;
            $display("CHECK FAILED at %0t: bus never ready", $time);
            summarize();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] data);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        haddr <= {22'h0, idx, 2'b00};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        data = hrdata;
        `TB_CHK(hresp, 1'b0)
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] dummy;
        bus(1'b1, idx, wd, dummy);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] got;
        bus(1'b0, idx, 32'h0, got);
        `TB_CHK(got, exp)
    endtask

    // arm one source level with every event suppressed, then fire the event under mask bit value m
    task automatic ev_test(input int k, input logic m);
        logic [8:0] s;
        logic [7:0] mk;
        s = sense_in;
        mk = 8'hFF;
        mk[ev_bit[k]] = m;
        for (int i = 0; i < 3; i++) begin
            wr(idx_of[i], 32'hFF);
        end
        s[ev_src[k]] = !ev_rise[k];
        sense_in <= s;
        repeat (8) @(posedge hclk);
        wr(`PRM_IDX_FLAGS, 32'h1FF);
        wr(idx_of[ev_grp[k]], {24'h0, mk});
        s[ev_src[k]] = ev_rise[k];
        sense_in <= s;
        repeat (8) @(posedge hclk);
        rdchk(`PRM_IDX_FLAGS, exp_flags(ev_src[k], m));
        rdchk(`PRM_IDX_RAW, {23'h0, s});
        `TB_CHK(irq, !m)
        if (!m) begin
            wr(`PRM_IDX_FLAG_MASK, 32'h1 << ev_src[k]);
            repeat (2) @(posedge hclk);
            `TB_CHK(irq, 1'b0)
            wr(`PRM_IDX_FLAG_MASK, 32'h0);
            repeat (2) @(posedge hclk);
            `TB_CHK(irq, 1'b1)
            wr(`PRM_IDX_FLAGS, 32'h1FF);
            repeat (2) @(posedge hclk);
            `TB_CHK(irq, 1'b0)
        end
    endtask

    initial begin
        logic [31:0] v;
        rd = $urandom(38432);
        hresetn <= 1'b0;
        hsel <= 1'b0;
        haddr <= 32'h0;
        htrans <= 2'b00;
        hwrite <= 1'b0;
        hsize <= 3'b010;
        hwdata <= 32'h0;
        sense_in <= 9'h000;
        otp_mask_default <= 24'($urandom());
        repeat (5) @(posedge hclk);
        `TB_CHK(irq, 1'b0)
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rdchk(`PRM_IDX_STEP_DOWN, exp_default(otp_mask_default[7:0], `PRM_DEF_STEP_DOWN));
        rdchk(`PRM_IDX_BOOST, exp_default(otp_mask_default[15:8], `PRM_DEF_BOOST));
        rdchk(`PRM_IDX_DIAG, exp_default(otp_mask_default[23:16], `PRM_DEF_DIAG));
        for (int i = 0; i < 3; i++) begin
            v = $urandom();
            wr(idx_of[i], v);
            rdchk(idx_of[i], {24'h0, v[7:0]});
        end
        wr(8'h10, 32'hFFFF_FFFF);
        rdchk(8'h10, 32'h0000_0000);
        for (int k = 0; k < 15; k++) begin
            ev_test(k, 1'b0);
            ev_test(k, 1'b1);
        end
        for (int r = 0; r < 20; r++) begin
            ev_test(int'($urandom_range(14)), 1'($urandom()));
        end
        summarize();
    end
endmodule

`default_nettype wire
